// file: logic/cpu_front_pkg.sv
// Package for the processor mode, register and decode front end.
// Assumes one 40 MHz clock and 36-bit Avalon-MM register access.
// Summary of operation
// - Processor is always in exactly one mode: absolute, master or slave.
// - All assigned opcodes run in absolute and master; privileged ones fault in slave.
// - Master and slave fetches are translated; absolute bypasses, except some operands.
// - Accumulator is 36-bit single operand; separate 8-bit exponent register.
// - Accumulator and quotient halves each selectable as index values.
// - Accumulator and quotient join into a 72-bit double-length pair.
// - Eight 18-bit index registers modify addresses and hold half operands.
// - 24-bit timer counts 64 kHz ticks or, when switched, memory cycles.
// - Timer loadable; reaching zero in slave mode raises a processor fault.
// - 18-bit flag register holds condition, mask and absolute bits; masks suppress errors.
// - With absolute flag set, fetch address is the fetch pointer alone.
// - Opcode space is 512 codes, 404 assigned, the rest reserved.
// - Instruction has 18-bit address, 9-bit opcode, control bits, 6-bit modifier.
// - Instruction bit 28 inhibits program interrupt acceptance around it.
// - Instruction bit 29 selects plain or base-relative address interpretation.
// - Modifier selects none, a register, indirection or special methods.
// - Compare results go into flags for later conditional transfers.
// - Four modification classes: register, reg-then-indirect, indirect-then-reg, indirect-then-tally.
// - Modification registers are index, accumulator/quotient halves, fetch pointer; direct operands.
// - Shifts and rotates act on accumulator, quotient or the pair.
// - Data moves handle half, single, double words and 6/9-bit characters.
// - Register modification adds register contents to the address field.
// - Reg-then-indirect fetches an indirect word, whose modifier applies likewise.
package cpu_front_pkg;
  localparam int DATA_W = 36;
  localparam int ADDR_W = 5;

  localparam logic [4:0] OFS_MODE     = 5'h00;
  localparam logic [4:0] OFS_ACC      = 5'h01;
  localparam logic [4:0] OFS_QUOT     = 5'h02;
  localparam logic [4:0] OFS_EXP      = 5'h03;
  localparam logic [4:0] OFS_FLAGS    = 5'h04;
  localparam logic [4:0] OFS_TIMER    = 5'h05;
  localparam logic [4:0] OFS_TIMER_CTL = 5'h06;
  localparam logic [4:0] OFS_IC       = 5'h07;
  localparam logic [4:0] OFS_INSTR    = 5'h08;
  localparam logic [4:0] OFS_STATUS   = 5'h09;
  localparam logic [4:0] OFS_EA       = 5'h0A;
  localparam logic [4:0] OFS_COMPARE  = 5'h0B;
  localparam logic [4:0] OFS_SHIFT    = 5'h0C;
  localparam logic [4:0] OFS_SEGTAB   = 5'h0D;
  localparam logic [4:0] OFS_CODEBASE = 5'h0E;
  localparam logic [4:0] OFS_INDEX0   = 5'h10;
  localparam logic [4:0] OFS_OPBASE0  = 5'h18;

  // Flag bit positions
  localparam int FL_ZERO = 0;
  localparam int FL_NEG = 1;
  localparam int FL_CARRY = 2;
  localparam int FL_OVF = 3;
  localparam int FL_EXP_OVF = 4;
  localparam int FL_EXP_UNF = 5;
  localparam int FL_OVF_MASK = 6;
  localparam int FL_TALLY = 7;
  localparam int FL_PAR_ERR = 8;
  localparam int FL_PAR_MASK = 9;
  localparam int FL_ABS = 10;

  // Status bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_EA_VALID = 1;
  localparam int ST_DIRECT = 2;
  localparam int ST_PRIV_FLT = 3;
  localparam int ST_ILL_FLT = 4;
  localparam int ST_TIMER_FLT = 5;
  localparam int ST_SIZE_LSB = 6;

  localparam logic [8:0] ASSIGNED_CODES = 9'h194;
  localparam logic [8:0] PRIV_BASE = 9'h180;
  localparam int TICK_NS = 15625;
  localparam int CLK_NS = 25;
  localparam int TICK_CYCLES = TICK_NS / CLK_NS;
  localparam logic [17:0] FLAGS_RST = 18'h00400;

  typedef enum logic [1:0] {MODE_ABSOLUTE, MODE_MASTER, MODE_SLAVE} cpu_mode_t;
  typedef enum logic [1:0] {CLS_REG, CLS_RI, CLS_IT, CLS_IR} mod_class_t;
  typedef enum logic [2:0] {SZ_HALF, SZ_SINGLE, SZ_DOUBLE, SZ_CHAR6, SZ_CHAR9} opnd_size_t;

  // Bit 0 of the documented word is the MSB here
  typedef struct packed {
    logic [17:0] y;
    logic [8:0]  opcode;
    logic        spare;
    logic        intr_inhibit;
    logic        base_rel;
    logic [5:0]  tag;
  } instr_t;

  typedef struct packed {
    logic [17:0] y;
    logic [11:0] tally;
    logic [5:0]  tag;
  } ind_word_t;
endpackage

// file: logic/addr_modifier.sv
// Register modification adder: picks a modification register and adds it.
// Assumes the caller holds all inputs stable for the cycle.
`timescale 1ns/10ps
`default_nettype none
module addr_modifier
  import cpu_front_pkg::*;
(
  input  wire logic [3:0]       td,
  input  wire logic [17:0]      y,
  input  wire logic [35:0]      acc,
  input  wire logic [35:0]      quot,
  input  wire logic [17:0]      ic,
  input  wire logic [7:0][17:0] index,
  output logic      [17:0]      ea,
  output logic                  direct
);
  logic [17:0] mreg;

  always_comb
  begin
    direct = 1'b0;
    case (td)
      4'h0: mreg = 18'h00000;
      4'h1: mreg = acc[35:18];
      4'h2: mreg = quot[35:18];
      4'h4: mreg = ic;
      4'h5: mreg = acc[17:0];
      4'h6: mreg = quot[17:0];
      4'h3, 4'h7:
      begin
        mreg = 18'h00000;
        direct = 1'b1;
      end
      default: mreg = index[td[2:0]];
    endcase
  end

  assign ea = mreg + y;
endmodule
`default_nettype wire

// file: logic/cpu_front.sv
// Processor front end: modes, program registers, flags, timer and decode.
// Assumes an Avalon-MM master and a simple indirect-word fetch responder.
//
// Chosen here: the register addresses and the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none
module cpu_front
  import cpu_front_pkg::*;
(
  input  wire logic                         clk,
  input  wire logic                         rst,
  input  wire logic [cpu_front_pkg::ADDR_W-1:0] address,
  input  wire logic                         read,
  input  wire logic                         write,
  input  wire logic [cpu_front_pkg::DATA_W-1:0] writedata,
  output logic      [cpu_front_pkg::DATA_W-1:0] readdata,
  output logic                              waitrequest,
  input  wire logic                         mem_cycle,
  input  wire logic                         parity_err_in,
  output logic                              ind_req,
  output logic      [17:0]                  ind_addr,
  input  wire logic                         ind_ready,
  input  wire logic [35:0]                  ind_word,
  output logic      [23:0]                  fetch_addr,
  output logic                              translate_bypass,
  output logic                              intr_inhibit,
  output logic                              base_relative,
  output logic                              proc_fault,
  output logic                              ovf_fault,
  output logic                              parity_fault
);
  import cpu_front_pkg::*;

  typedef enum logic [1:0] {S_IDLE, S_MOD, S_FETCH} seq_t;

  cpu_mode_t        mode_r;
  logic [35:0]      acc_r;
  logic [35:0]      quot_r;
  logic [7:0]       exp_r;
  logic [17:0]      flags_r;
  logic [23:0]      timer_r;
  logic             count_mem_r;
  logic [17:0]      ic_r;
  instr_t           instr_r;
  logic [28:0]      segtab_r;
  logic [17:0]      codebase_r;
  logic [7:0][17:0] index_r;
  logic [7:0][23:0] opbase_r;
  logic [9:0]       presc_r;
  logic             rd_ack_r;
  seq_t             seq_r;
  logic [17:0]      cur_y_r;
  logic [5:0]       cur_tag_r;
  logic [3:0]       saved_td_r;
  logic             ir_pend_r;
  logic             it_r;
  logic [17:0]      ea_r;
  logic             ea_valid_r;
  logic             direct_r;
  logic [35:0]      operand_r;
  logic             priv_flt_r;
  logic             ill_flt_r;
  logic             timer_flt_r;
  logic [17:0]      ind_addr_r;
  logic [23:0]      fetch_addr_r;

  logic        wr_acc;
  logic        tick;
  logic        start;
  logic [3:0]  use_td;
  logic [17:0] mod_ea;
  logic        mod_direct;
  ind_word_t   iw;
  mod_class_t  cls;

  // Privileged opcodes sit in the top of the assigned range
  function automatic logic is_priv(input logic [8:0] op);
    return (op >= PRIV_BASE) && (op < ASSIGNED_CODES);
  endfunction

  // Operand size from opcode low bits; character codes in the top pair
  function automatic opnd_size_t op_size(input logic [8:0] op);
    case (op[2:0])
      3'h0, 3'h1: return SZ_HALF;
      3'h2, 3'h3: return SZ_SINGLE;
      3'h4, 3'h5: return SZ_DOUBLE;
      3'h6: return SZ_CHAR6;
      default: return SZ_CHAR9;
    endcase
  endfunction

  // Shift or rotate of a 36- or 72-bit value held right-aligned
  function automatic logic [71:0] shift_op(input logic [71:0] v, input logic [6:0] n,
                                           input logic left, input logic rot,
                                           input logic dbl);
    logic [71:0] r;
    logic [71:0] msk;
    logic [6:0]  w;
    w = dbl ? 7'd72 : 7'd36;
    msk = dbl ? {72{1'b1}} : {36'h0, 36'hFFFFFFFFF};
    if (n >= w)
      r = rot ? v : 72'h0;
    else if (left)
      r = (v << n) | (rot ? (v >> (w - n)) : 72'h0);
    else
      r = (v >> n) | (rot ? (v << (w - n)) : 72'h0);
    return r & msk;
  endfunction

  assign wr_acc = write;
  assign waitrequest = read & ~rd_ack_r;
  assign start = wr_acc && address == OFS_INSTR && seq_r == S_IDLE;
  assign iw = ind_word_t'(ind_word);
  assign cls = mod_class_t'(cur_tag_r[5:4]);
  assign use_td = (cls == CLS_REG && ir_pend_r) ? saved_td_r : cur_tag_r[3:0];

  addr_modifier u_mod (
    .td     (use_td),
    .y      (cur_y_r),
    .acc    (acc_r),
    .quot   (quot_r),
    .ic     (ic_r),
    .index  (index_r),
    .ea     (mod_ea),
    .direct (mod_direct)
  );

  // One wait state on reads so read data come from a flop
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rd_ack_r <= 1'b0;
    else
      rd_ack_r <= read & ~rd_ack_r;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      readdata <= 36'h000000000;
    else if (read && !rd_ack_r)
    begin
      readdata <= 36'h000000000;
      case (address)
        OFS_MODE: readdata[1:0] <= mode_r;
        OFS_ACC: readdata <= acc_r;
        OFS_QUOT: readdata <= quot_r;
        OFS_EXP: readdata[7:0] <= exp_r;
        OFS_FLAGS: readdata[17:0] <= flags_r;
        OFS_TIMER: readdata[23:0] <= timer_r;
        OFS_TIMER_CTL: readdata[0] <= count_mem_r;
        OFS_IC: readdata[17:0] <= ic_r;
        OFS_INSTR: readdata <= instr_r;
        OFS_STATUS:
        begin
          readdata[ST_BUSY] <= seq_r != S_IDLE;
          readdata[ST_EA_VALID] <= ea_valid_r;
          readdata[ST_DIRECT] <= direct_r;
          readdata[ST_PRIV_FLT] <= priv_flt_r;
          readdata[ST_ILL_FLT] <= ill_flt_r;
          readdata[ST_TIMER_FLT] <= timer_flt_r;
          readdata[ST_SIZE_LSB +: 3] <= op_size(instr_r.opcode);
        end
        OFS_EA: readdata <= direct_r ? operand_r : {18'h0, ea_r};
        OFS_SEGTAB: readdata[28:0] <= segtab_r;
        OFS_CODEBASE: readdata[17:0] <= codebase_r;
        default:
        begin
          if (address[4:3] == 2'b10)
            readdata[17:0] <= index_r[address[2:0]];
          else if (address[4:3] == 2'b11)
            readdata[23:0] <= opbase_r[address[2:0]];
        end
      endcase
    end
  end

  // Mode is a single encoded field, so one mode holds at a time
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      mode_r <= MODE_ABSOLUTE;
    else if (wr_acc && address == OFS_MODE && writedata[1:0] != 2'b11)
      mode_r <= cpu_mode_t'(writedata[1:0]);
  end

  // Accumulator and quotient: bus writes and shift commands
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      acc_r <= 36'h000000000;
      quot_r <= 36'h000000000;
    end
    else if (wr_acc && address == OFS_ACC)
      acc_r <= writedata;
    else if (wr_acc && address == OFS_QUOT)
      quot_r <= writedata;
    else if (wr_acc && address == OFS_SHIFT)
    begin
      case (writedata[1:0])
        2'h0: acc_r <= 36'(shift_op({36'h0, acc_r}, writedata[10:4], writedata[2],
                                    writedata[3], 1'b0));
        2'h1: quot_r <= 36'(shift_op({36'h0, quot_r}, writedata[10:4], writedata[2],
                                     writedata[3], 1'b0));
        2'h2: {acc_r, quot_r} <= shift_op({acc_r, quot_r}, writedata[10:4],
                                          writedata[2], writedata[3], 1'b1);
        default: acc_r <= acc_r;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      exp_r <= 8'h00;
      ic_r <= 18'h00000;
      segtab_r <= 29'h00000000;
      codebase_r <= 18'h00000;
      count_mem_r <= 1'b0;
    end
    else if (wr_acc)
    begin
      case (address)
        OFS_EXP: exp_r <= writedata[7:0];
        OFS_IC: ic_r <= writedata[17:0];
        OFS_SEGTAB: segtab_r <= writedata[28:0];
        OFS_CODEBASE: codebase_r <= writedata[17:0];
        OFS_TIMER_CTL: count_mem_r <= writedata[0];
        default: exp_r <= exp_r;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      index_r <= '0;
      opbase_r <= '0;
    end
    else if (wr_acc && address[4:3] == 2'b10)
      index_r[address[2:0]] <= writedata[17:0];
    else if (wr_acc && address[4:3] == 2'b11)
      opbase_r[address[2:0]] <= writedata[23:0];
  end

  // Flags: software writes, compare results, parity events
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      flags_r <= FLAGS_RST;
    else
    begin
      if (wr_acc && address == OFS_FLAGS)
        flags_r <= writedata[17:0];
      else if (wr_acc && address == OFS_COMPARE)
      begin
        flags_r[FL_ZERO] <= acc_r == writedata;
        flags_r[FL_NEG] <= acc_r[35] ^ writedata[35] ? acc_r[35] : acc_r < writedata;
        flags_r[FL_CARRY] <= acc_r >= writedata;
      end
      if (parity_err_in)
        flags_r[FL_PAR_ERR] <= 1'b1;
      flags_r[FL_ABS] <= mode_r == MODE_ABSOLUTE;
    end
  end

  assign ovf_fault = flags_r[FL_OVF] & ~flags_r[FL_OVF_MASK];
  assign parity_fault = flags_r[FL_PAR_ERR] & ~flags_r[FL_PAR_MASK];

  // 64 kHz tick prescaler
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      presc_r <= 10'h000;
    else if (presc_r == 10'(TICK_CYCLES - 1))
      presc_r <= 10'h000;
    else
      presc_r <= presc_r + 10'h001;
  end

  assign tick = count_mem_r ? mem_cycle : presc_r == 10'(TICK_CYCLES - 1);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      timer_r <= 24'h000000;
    else if (wr_acc && address == OFS_TIMER)
      timer_r <= writedata[23:0];
    else if (tick && timer_r != 24'h000000)
      timer_r <= timer_r - 24'h000001;
  end

  // Sticky faults; a new event wins over a write-one clear
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      priv_flt_r <= 1'b0;
      ill_flt_r <= 1'b0;
      timer_flt_r <= 1'b0;
    end
    else
    begin
      if (wr_acc && address == OFS_STATUS)
      begin
        if (writedata[ST_PRIV_FLT])
          priv_flt_r <= 1'b0;
        if (writedata[ST_ILL_FLT])
          ill_flt_r <= 1'b0;
        if (writedata[ST_TIMER_FLT])
          timer_flt_r <= 1'b0;
      end
      if (start && mode_r == MODE_SLAVE && is_priv(writedata[17:9]))
        priv_flt_r <= 1'b1;
      if (start && writedata[17:9] >= ASSIGNED_CODES)
        ill_flt_r <= 1'b1;
      if (tick && timer_r == 24'h000001 && mode_r == MODE_SLAVE
          && !(wr_acc && address == OFS_TIMER))
        timer_flt_r <= 1'b1;
    end
  end

  assign proc_fault = priv_flt_r | ill_flt_r | timer_flt_r;

  // Latched instruction drives its control bits
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      instr_r <= '0;
    else if (start)
      instr_r <= instr_t'(writedata);
  end

  assign intr_inhibit = instr_r.intr_inhibit;
  assign base_relative = instr_r.base_rel;

  // Address preparation sequence
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      seq_r <= S_IDLE;
      cur_y_r <= 18'h00000;
      cur_tag_r <= 6'h00;
      saved_td_r <= 4'h0;
      ir_pend_r <= 1'b0;
      it_r <= 1'b0;
      ea_r <= 18'h00000;
      ea_valid_r <= 1'b0;
      direct_r <= 1'b0;
      operand_r <= 36'h000000000;
      ind_addr_r <= 18'h00000;
    end
    else
    begin
      case (seq_r)
        S_IDLE:
        begin
          if (start && !(mode_r == MODE_SLAVE && is_priv(writedata[17:9]))
              && writedata[17:9] < ASSIGNED_CODES)
          begin
            cur_y_r <= writedata[35:18];
            cur_tag_r <= writedata[5:0];
            ir_pend_r <= 1'b0;
            it_r <= 1'b0;
            ea_valid_r <= 1'b0;
            direct_r <= 1'b0;
            seq_r <= S_MOD;
          end
        end
        S_MOD:
        begin
          case (cls)
            CLS_REG:
            begin
              ea_r <= mod_ea;
              direct_r <= mod_direct;
              operand_r <= use_td[2] ? {18'h0, cur_y_r} : {cur_y_r, 18'h0};
              ea_valid_r <= 1'b1;
              seq_r <= S_IDLE;
            end
            CLS_RI:
            begin
              ind_addr_r <= mod_ea;
              seq_r <= S_FETCH;
            end
            CLS_IR:
            begin
              saved_td_r <= cur_tag_r[3:0];
              ir_pend_r <= 1'b1;
              ind_addr_r <= cur_y_r;
              seq_r <= S_FETCH;
            end
            default:
            begin
              it_r <= 1'b1;
              ind_addr_r <= cur_y_r;
              seq_r <= S_FETCH;
            end
          endcase
        end
        S_FETCH:
        begin
          if (ind_ready)
          begin
            if (it_r)
            begin
              ea_r <= iw.y;
              ea_valid_r <= 1'b1;
              seq_r <= S_IDLE;
            end
            else
            begin
              cur_y_r <= iw.y;
              cur_tag_r <= iw.tag;
              seq_r <= S_MOD;
            end
          end
        end
        default: seq_r <= S_IDLE;
      endcase
    end
  end

  assign ind_req = seq_r == S_FETCH;
  assign ind_addr = ind_addr_r;

  // Absolute mode fetches straight from the pointer, untranslated
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      fetch_addr_r <= 24'h000000;
    else if (mode_r == MODE_ABSOLUTE || flags_r[FL_ABS])
      fetch_addr_r <= {6'h00, ic_r};
    else
      fetch_addr_r <= {6'h00, codebase_r} + {6'h00, ic_r};
  end

  assign fetch_addr = fetch_addr_r;
  assign translate_bypass = mode_r == MODE_ABSOLUTE;
endmodule
`default_nettype wire

// file: dv/cpu_front_monitor.sv
// Checker for the front end ports: bus timing, decode and fetch link.
// Assumes binding to cpu_front and one clock domain.
`timescale 1ns/10ps
`default_nettype none
module cpu_front_monitor
  import cpu_front_pkg::*;
(
  input wire logic                              clk,
  input wire logic                              rst,
  input wire logic [cpu_front_pkg::ADDR_W-1:0]  address,
  input wire logic                              read,
  input wire logic                              write,
  input wire logic [cpu_front_pkg::DATA_W-1:0]  writedata,
  input wire logic                              waitrequest,
  input wire logic                              ind_req,
  input wire logic [17:0]                       ind_addr,
  input wire logic                              ind_ready,
  input wire logic [23:0]                       fetch_addr,
  input wire logic                              translate_bypass,
  input wire logic                              intr_inhibit,
  input wire logic                              base_relative
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [17:0] ic_w_r;
  wire logic   iw = write && address == OFS_INSTR && writedata[17:9] < PRIV_BASE;
  always_ff @(posedge clk)
    if (write && address == OFS_IC)
      ic_w_r <= writedata[17:0];

  a_read_wait: assert property ($rose(read) |-> waitrequest ##1 !waitrequest)
    else $error("read wait state wrong");
  a_mode_abs: assert property (write && address == OFS_MODE && writedata == 36'h0 |=> translate_bypass)
    else $error("absolute mode not bypassing");
  a_mode_xlat: assert property (write && address == OFS_MODE && writedata inside {36'h1, 36'h2}
    |=> !translate_bypass)
    else $error("translated mode bypassing");
  a_ind_hold: assert property (ind_req && !ind_ready |=> ind_req && $stable(ind_addr))
    else $error("indirect request dropped");
  a_ri_fetch: assert property (iw && writedata[5:4] == 2'h1 |-> ##[1:3] ind_req)
    else $error("no indirect fetch");
  a_reg_noind: assert property (iw && writedata[5:4] == 2'h0 |=> !ind_req [*3])
    else $error("register class fetched");
  a_inh_bit: assert property (iw |=> intr_inhibit == $past(writedata[7]))
    else $error("inhibit bit wrong");
  a_base_bit: assert property (iw |=> base_relative == $past(writedata[6]))
    else $error("base bit wrong");
  a_fetch_abs: assert property (write && address == OFS_IC && translate_bypass
    |-> ##2 fetch_addr == {6'h00, ic_w_r})
    else $error("absolute fetch address wrong");
endmodule
bind cpu_front cpu_front_monitor mon_u (.clk, .rst, .address, .read, .write, .writedata, .waitrequest,
  .ind_req, .ind_addr, .ind_ready, .fetch_addr, .translate_bypass, .intr_inhibit, .base_relative);
`default_nettype wire

// file: dv/ind_responder.sv
// Memory-side model answering indirect word fetches.
// Assumes lat idle cycles before each answer; words end the chain.
`timescale 1ns/10ps
`default_nettype none
module ind_responder
(
  input wire logic         clk,
  input wire logic         rst,
  input wire logic [3:0]   lat,
  input wire logic         ind_req,
  input wire logic [17:0]  ind_addr,
  output logic             ind_ready,
  output logic [35:0]      ind_word
);
  logic [3:0] cnt_r;
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      cnt_r <= 4'h0;
      ind_ready <= 1'b0;
      ind_word <= 36'h0;
    end
    else if (ind_req && !ind_ready && cnt_r < lat)
      cnt_r <= cnt_r + 4'h1;
    else if (ind_req && !ind_ready)
    begin
      cnt_r <= 4'h0;
      ind_ready <= 1'b1;
      ind_word <= {ind_addr + 18'h00100, 12'h000, 6'h00};
    end
    else
    begin
      ind_ready <= 1'b0;
      // Stale word inverted so nothing relies on it
      ind_word <= ~ind_word;
    end
endmodule
`default_nettype wire

// file: dv/tb.sv
// Self-checking bench for cpu_front.
// Assumes the Avalon register map and the indirect responder model.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import cpu_front_pkg::*;
  logic clk = 1'b0, rst = 1'b1, read = 1'b0, write = 1'b0, mem_cycle = 1'b0, par = 1'b0;
  logic [4:0] address = 5'h00;
  logic [3:0] lat = 4'h0;
  logic [35:0] writedata = 36'h0, readdata, ind_word, v;
  logic waitrequest, ind_req, ind_ready, byp, inh, brel, proc_fault, ovf_fault, parity_fault;
  logic [17:0] ind_addr;
  logic [23:0] fetch_addr;
  int miscompares = 0, n_checks = 0;
  always #12.5 clk = ~clk;
  cpu_front dut_u (.clk, .rst, .address, .read, .write, .writedata, .readdata, .waitrequest,
    .mem_cycle, .parity_err_in(par), .ind_req, .ind_addr, .ind_ready, .ind_word, .fetch_addr,
    .translate_bypass(byp), .intr_inhibit(inh), .base_relative(brel), .proc_fault, .ovf_fault,
    .parity_fault);
  ind_responder rsp_u (.clk, .rst, .lat, .ind_req, .ind_addr, .ind_ready, .ind_word);
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Request stands until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [4:0] a, input logic [35:0] d);
    int n;
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
      if (n > 50)
      begin
        miscompares++;
        report_and_stop();
      end
    end
    while (waitrequest !== 1'b0);
    v = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask
  function automatic instr_t mk(input logic [17:0] y, input logic [8:0] op, input logic [5:0] tg);
    mk = instr_t'{y, op, 1'b0, op[0], op[1], tg};
  endfunction
  task automatic issue(input instr_t w, input logic [35:0] ea);
    int n;
    bus(1'b1, OFS_INSTR, w);
    n = 0;
    do
    begin
      bus(1'b0, OFS_STATUS, 36'h0);
      n++;
    end
    while (v[1:0] !== 2'b10 && n < 20);
    chk(v[1:0], 2'b10);
    if (v[1:0] !== 2'b10)
      report_and_stop();
    bus(1'b0, OFS_EA, 36'h0);
    chk(v, ea);
  endtask
  task automatic t_regs;
    bus(1'b1, OFS_ACC, 36'hFEDCBA987);
    bus(1'b0, OFS_ACC, 36'h0);
    chk(v, 36'hFEDCBA987);
    bus(1'b1, OFS_EXP, 36'hFFFFFFFFF);
    bus(1'b0, OFS_EXP, 36'h0);
    chk(v, 36'h0000000FF);
    bus(1'b1, OFS_INDEX0 + 5'h07, 36'hFFFFFFFFF);
    bus(1'b0, OFS_INDEX0 + 5'h07, 36'h0);
    chk(v, 36'h00003FFFF);
    bus(1'b0, 5'h0F, 36'h0);
    chk(v, 36'h0);
    bus(1'b1, OFS_IC, 36'h12345);
    bus(1'b1, OFS_CODEBASE, 36'h00100);
    chk(fetch_addr, 24'h012345);
    bus(1'b1, OFS_MODE, 36'h1);
    // Absolute flag trails the mode by a cycle
    repeat (3) @(negedge clk);
    chk(fetch_addr, 24'h012445);
  endtask
  task automatic t_modes;
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b1, OFS_MODE, 36'(i));
      bus(1'b0, OFS_MODE, 36'h0);
      chk(v, 36'((i == 3) ? 2 : i));
      chk(byp, i == 0);
      bus(1'b0, OFS_FLAGS, 36'h0);
      chk(v[10], i == 0);
    end
  endtask
  task automatic t_op(input logic [1:0] m, input logic [8:0] op, input logic [1:0] flt, input logic [2:0] sz);
    bus(1'b1, OFS_MODE, {34'h0, m});
    bus(1'b1, OFS_INSTR, mk(18'h00100, op, 6'h00));
    bus(1'b0, OFS_STATUS, 36'h0);
    chk(v[4:3], flt);
    chk(v[8:6], sz);
    chk(proc_fault, flt != 2'b00);
    bus(1'b1, OFS_STATUS, 36'h38);
    repeat (4) @(posedge clk);
  endtask
  task automatic pulse_mem;
    @(posedge clk);
    mem_cycle <= 1'b1;
    @(posedge clk);
    mem_cycle <= 1'b0;
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_modes();
    t_op(2'h2, 9'h180, 2'b01, SZ_HALF);
    t_op(2'h2, 9'h194, 2'b10, SZ_DOUBLE);
    t_op(2'h1, 9'h193, 2'b00, SZ_SINGLE);
    t_op(2'h0, 9'h1FF, 2'b10, SZ_CHAR9);
    bus(1'b1, OFS_INDEX0, 36'h10);
    bus(1'b1, OFS_ACC, {18'h00020, 18'h00007});
    issue(mk(18'h00100, 9'h001, 6'h08), 36'h110);
    issue(mk(18'h00100, 9'h002, 6'h01), 36'h120);
    issue(mk(18'h00100, 9'h003, 6'h05), 36'h107);
    issue(mk(18'h00100, 9'h002, 6'h03), 36'h004000000);
    issue(mk(18'h00200, 9'h001, 6'h10), 36'h300);
    lat <= 4'h5;
    issue(mk(18'h00200, 9'h002, 6'h18), 36'h310);
    issue(mk(18'h00200, 9'h000, 6'h20), 36'h300);
    issue(mk(18'h00200, 9'h003, 6'h38), 36'h310);
    bus(1'b1, OFS_ACC, 36'h5);
    bus(1'b1, OFS_COMPARE, 36'h5);
    bus(1'b0, OFS_FLAGS, 36'h0);
    chk(v[2:0], 3'b101);
    bus(1'b1, OFS_COMPARE, 36'h6);
    bus(1'b0, OFS_FLAGS, 36'h0);
    chk(v[2:0], 3'b010);
    bus(1'b1, OFS_ACC, 36'h1);
    bus(1'b1, OFS_SHIFT, 36'h44);
    bus(1'b0, OFS_ACC, 36'h0);
    chk(v, 36'h10);
    bus(1'b1, OFS_QUOT, 36'h1);
    bus(1'b1, OFS_SHIFT, 36'h19);
    bus(1'b0, OFS_QUOT, 36'h0);
    chk(v, 36'h800000000);
    bus(1'b1, OFS_ACC, 36'h0);
    bus(1'b1, OFS_SHIFT, 36'h16);
    bus(1'b0, OFS_ACC, 36'h0);
    chk(v, 36'h1);
    @(posedge clk);
    par <= 1'b1;
    @(posedge clk);
    par <= 1'b0;
    @(negedge clk);
    chk(parity_fault, 1'b1);
    bus(1'b1, OFS_FLAGS, 36'h208);
    @(negedge clk);
    chk(parity_fault, 1'b0);
    chk(ovf_fault, 1'b1);
    bus(1'b1, OFS_FLAGS, 36'h048);
    @(negedge clk);
    chk(ovf_fault, 1'b0);
    bus(1'b1, OFS_MODE, 36'h2);
    bus(1'b1, OFS_TIMER_CTL, 36'h1);
    bus(1'b1, OFS_TIMER, 36'h3);
    pulse_mem();
    pulse_mem();
    bus(1'b0, OFS_TIMER, 36'h0);
    chk(v, 36'h1);
    chk(proc_fault, 1'b0);
    pulse_mem();
    bus(1'b0, OFS_STATUS, 36'h0);
    chk(v[5], 1'b1);
    chk(proc_fault, 1'b1);
    report_and_stop();
  end
endmodule
`default_nettype wire
